// file: src/dds_core_pkg.sv
// package for the synthesizer core: register map, field layout, reset values, state types
// assumes an apb slave with 32-bit data; register indexes are word indexes
package dds_core_pkg;
  // register indexes, byte address is four times the index
  localparam logic [13:0] IDX_FINE_DIV = 14'h0023;
  localparam logic [13:0] IDX_PLL_CTL = 14'h0100;
  localparam logic [13:0] IDX_FINE_GAIN = 14'h0404;
  localparam logic [13:0] IDX_SCALE_LO = 14'h040B;
  localparam logic [13:0] IDX_SCALE_HI = 14'h040C;
  localparam logic [13:0] IDX_TUNE_LO = 14'h0010;
  localparam logic [13:0] IDX_TUNE_HI = 14'h0011;
  localparam logic [13:0] IDX_PHASE_OFS = 14'h0012;
  localparam logic [13:0] IDX_COARSE_GAIN = 14'h0013;
  localparam logic [13:0] IDX_STATUS = 14'h0014;
  // pll control bit positions
  localparam int CTL_CLOSE = 0;
  localparam int CTL_HOLD_MAN = 1;
  localparam int CTL_HOLD_AUTO = 2;
  localparam int CTL_EST_SRC = 3;
  // reset values
  localparam logic [3:0] RST_FINE_DIV = 4'h5;
  localparam logic [7:0] RST_FINE_GAIN = 8'hC8;
  localparam logic [9:0] RST_SCALE = 10'h000;
  localparam logic [7:0] RST_PLL_CTL = 8'h00;
  localparam logic [8:0] RST_COARSE_GAIN = 9'h000;
  // coarse counter saturation (over 262 us at 1 GHz)
  localparam logic [17:0] COARSE_MAX = 18'h3FFFF;

  typedef enum logic [1:0] {PD_IDLE, PD_REF_LEAD, PD_FB_LEAD} pd_state_t;
  typedef enum logic [1:0] {MODE_TONE, MODE_HOLD, MODE_CLOSED} syn_mode_t;

  // apb request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // complete block state
  typedef struct packed {
    logic [47:0] acc;
    logic [13:0] sine_phase;
    logic [47:0] tuning_step_word;
    logic [47:0] stored_tuning_word;
    logic [47:0] hold_word;
    logic [13:0] phase_ofs;
    logic [7:0] pll_ctl;
    logic [3:0] fine_detector_divider;
    logic [7:0] fine_detector_gain;
    logic [9:0] dac_current_scale;
    logic [2:0] coarse_gain_exponent;
    logic [5:0] coarse_gain_multiplier;
    syn_mode_t mode;
    logic locked_once;
    pd_state_t pd;
    logic [17:0] coarse_cnt;
    logic signed [18:0] coarse_meas;
    logic [5:0] tick_cnt;
    logic fine_tick;
    logic signed [31:0] phase_err;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_state_t;
endpackage

// file: src/dds_core_phase_detector.sv
// synthesizer core: phase accumulator, mode selection, converter scale and phase detector
// assumes apb master on mclk, edge pulses and fine results synchronous to mclk
//
// Summary of operation
// [RL1] 48-bit tuning step added to accumulator each cycle
// [RL2] accumulator wraps modulo 2^48, keeps remainder
// [RL3] 14-bit phase offset shifts output phase
// [RL4] control bit 0 at 0x0100 closes loop
// [RL5] single tone uses stored word, ignores references
// [RL6] software alone selects single tone mode; with bit 0 clear, auto holdover also falls back to it when ref_lost clears
// [RL7] single tone drops tuning word lsb
// [RL8] estimator may supply tuning and phase words
// [RL9] holdover replays word recorded while loop closed
// [RL10] holdover entry automatic or manual by register
// [RL11] closed loop takes loop filter word continuously
// [RL12] closed loop ignores programmed phase offset
// [RL13] 10-bit converter scale across 0x040B/0x040C
// [RL14] coarse detector counts clock cycles between edges
// [RL15] coarse gain is 2^(exp+6) times multiplier
// [RL16] fine sample rate is clock over 4*divider
// [RL17] fine gain 8-bit at 0x0404, default 200
// [RL18] software matches coarse gain to fine gain
// [RL19] fine result used unless over/underflow, else coarse
// [RL20] offset added to top 14 phase bits
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dds_core_phase_detector (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frequency estimator and loop filter words
  input wire logic [47:0] est_tuning_word,
  input wire logic [13:0] est_phase_word,
  input wire logic [47:0] loop_tuning_word,
  input wire logic ref_lost,
  // detector inputs
  input wire logic ref_edge,
  input wire logic fb_edge,
  input wire logic signed [15:0] fine_meas,
  input wire logic fine_over,
  input wire logic fine_under,
  // outputs to sine lookup, converter and loop filter
  output logic [13:0] sine_phase,
  output logic [9:0] dac_current_scale,
  output logic signed [31:0] phase_err,
  output logic fine_tick
);
  dds_core_pkg::core_state_t s;
  dds_core_pkg::core_state_t next_s;
  dds_core_pkg::apb_req_t req;
  logic [13:0] idx;
  logic wr_go;
  logic rd_go;
  logic mapped;
  logic [31:0] rd_val;
  logic hold_req;
  logic [47:0] step;
  logic [13:0] ofs;
  logic [5:0] tick_len;
  logic signed [31:0] coarse_scaled;
  logic signed [31:0] fine_scaled;

  // bus request bundle and decode
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign idx = req.addr[15:2];
  assign wr_go = req.sel & req.enable & s.pready & req.write;
  assign rd_go = req.sel & req.enable & ~s.pready & ~req.write;
  assign mapped = (idx == dds_core_pkg::IDX_FINE_DIV) | (idx == dds_core_pkg::IDX_PLL_CTL) |
                  (idx == dds_core_pkg::IDX_FINE_GAIN) | (idx == dds_core_pkg::IDX_SCALE_LO) |
                  (idx == dds_core_pkg::IDX_SCALE_HI) | (idx == dds_core_pkg::IDX_TUNE_LO) |
                  (idx == dds_core_pkg::IDX_TUNE_HI) | (idx == dds_core_pkg::IDX_PHASE_OFS) |
                  (idx == dds_core_pkg::IDX_COARSE_GAIN) | (idx == dds_core_pkg::IDX_STATUS);

  // read multiplexer
  always_comb begin
    case (idx)
      dds_core_pkg::IDX_FINE_DIV: rd_val = {28'h0000000, s.fine_detector_divider};
      dds_core_pkg::IDX_PLL_CTL: rd_val = {24'h000000, s.pll_ctl};
      dds_core_pkg::IDX_FINE_GAIN: rd_val = {24'h000000, s.fine_detector_gain};
      dds_core_pkg::IDX_SCALE_LO: rd_val = {24'h000000, s.dac_current_scale[7:0]};
      dds_core_pkg::IDX_SCALE_HI: rd_val = {30'h00000000, s.dac_current_scale[9:8]};
      dds_core_pkg::IDX_TUNE_LO: rd_val = s.stored_tuning_word[31:0];
      dds_core_pkg::IDX_TUNE_HI: rd_val = {16'h0000, s.stored_tuning_word[47:32]};
      dds_core_pkg::IDX_PHASE_OFS: rd_val = {18'h00000, s.phase_ofs};
      dds_core_pkg::IDX_COARSE_GAIN: rd_val = {23'h000000, s.coarse_gain_exponent, s.coarse_gain_multiplier};
      dds_core_pkg::IDX_STATUS: rd_val = {28'h0000000, s.pd, s.locked_once, s.mode == dds_core_pkg::MODE_HOLD};
      default: rd_val = 32'h00000000;
    endcase
  end

  // mode-dependent step and offset selection
  always_comb begin
    hold_req = s.locked_once & ((s.pll_ctl[dds_core_pkg::CTL_HOLD_MAN]) |
               (s.pll_ctl[dds_core_pkg::CTL_HOLD_AUTO] & ref_lost)); // see [RL9] see [RL10]
    tick_len = {s.fine_detector_divider, 2'b00}; // see [RL16]
    case (s.mode)
      dds_core_pkg::MODE_CLOSED: begin
        step = loop_tuning_word; // see [RL11]
        ofs = 14'h0000; // see [RL12]
      end
      dds_core_pkg::MODE_HOLD: begin
        step = s.hold_word; // see [RL9]
        ofs = s.phase_ofs;
      end
      default: begin
        // single tone ignores both references
        if (s.pll_ctl[dds_core_pkg::CTL_EST_SRC]) begin
          step = {est_tuning_word[47:1], 1'b0}; // see [RL8] see [RL7]
          ofs = est_phase_word;
        end else begin
          step = {s.stored_tuning_word[47:1], 1'b0}; // see [RL5] see [RL7]
          ofs = s.phase_ofs; // see [RL3]
        end
      end
    endcase
  end

  // detector gain scaling
  always_comb begin
    // widen before multiplying so the product and shift keep their upper bits
    coarse_scaled = (32'(s.coarse_meas) * $signed({26'h0000000, s.coarse_gain_multiplier}))
                    <<< ({1'b0, s.coarse_gain_exponent} + 4'd6); // see [RL15]
    fine_scaled = 32'(fine_meas) * $signed({24'h000000, s.fine_detector_gain}); // see [RL17]
  end

  // next-state logic
  always_comb begin
    next_s = s;
    // accumulator wraps and keeps the excess
    next_s.acc = s.acc + s.tuning_step_word; // see [RL1] see [RL2]
    next_s.tuning_step_word = step;
    next_s.sine_phase = s.acc[47:34] + ofs; // see [RL20] see [RL3]
    // mode: hold request first, closed by control bit, else tone
    if (s.pll_ctl[dds_core_pkg::CTL_CLOSE] & ~hold_req) begin
      next_s.mode = dds_core_pkg::MODE_CLOSED; // see [RL4]
    end else if (hold_req) begin
      next_s.mode = dds_core_pkg::MODE_HOLD; // see [RL10]
    end else begin
      next_s.mode = dds_core_pkg::MODE_TONE; // see [RL6]
    end
    // record the loop word while closed
    if (s.mode == dds_core_pkg::MODE_CLOSED) begin
      next_s.hold_word = loop_tuning_word; // see [RL9]
      next_s.locked_once = 1'b1;
    end
    // three-state detector with cycle counter
    case (s.pd)
      dds_core_pkg::PD_IDLE: begin
        next_s.coarse_cnt = 18'h00001;
        if (ref_edge & fb_edge) begin
          next_s.coarse_meas = 19'sh00000;
        end else if (ref_edge) begin
          next_s.pd = dds_core_pkg::PD_REF_LEAD;
        end else if (fb_edge) begin
          next_s.pd = dds_core_pkg::PD_FB_LEAD;
        end
      end
      dds_core_pkg::PD_REF_LEAD: begin
        if (fb_edge) begin
          next_s.coarse_meas = $signed({1'b0, s.coarse_cnt}); // see [RL14]
          next_s.pd = dds_core_pkg::PD_IDLE;
        end else if (s.coarse_cnt != dds_core_pkg::COARSE_MAX) begin
          next_s.coarse_cnt = s.coarse_cnt + 18'h00001;
        end
      end
      dds_core_pkg::PD_FB_LEAD: begin
        if (ref_edge) begin
          next_s.coarse_meas = -$signed({1'b0, s.coarse_cnt}); // see [RL14]
          next_s.pd = dds_core_pkg::PD_IDLE;
        end else if (s.coarse_cnt != dds_core_pkg::COARSE_MAX) begin
          next_s.coarse_cnt = s.coarse_cnt + 18'h00001;
        end
      end
      default: next_s.pd = dds_core_pkg::PD_IDLE;
    endcase
    // fine sample tick every 4*divider cycles
    next_s.fine_tick = 1'b0;
    if (s.tick_cnt + 6'd1 >= tick_len) begin
      next_s.tick_cnt = 6'd0;
      next_s.fine_tick = 1'b1; // see [RL16]
      // fine result unless out of range
      next_s.phase_err = (fine_over | fine_under) ? coarse_scaled : fine_scaled; // see [RL19]
    end else begin
      next_s.tick_cnt = s.tick_cnt + 6'd1;
    end
    // apb: one wait state, answer in second access cycle
    next_s.pready = req.sel & req.enable & ~s.pready;
    next_s.pslverr = req.sel & req.enable & ~s.pready & ~mapped;
    if (rd_go) begin
      next_s.prdata = mapped ? rd_val : 32'h00000000;
    end
    if (wr_go) begin
      case (idx)
        dds_core_pkg::IDX_FINE_DIV: next_s.fine_detector_divider = req.wdata[3:0];
        dds_core_pkg::IDX_PLL_CTL: next_s.pll_ctl = req.wdata[7:0]; // see [RL4]
        dds_core_pkg::IDX_FINE_GAIN: next_s.fine_detector_gain = req.wdata[7:0];
        dds_core_pkg::IDX_SCALE_LO: next_s.dac_current_scale[7:0] = req.wdata[7:0]; // see [RL13]
        dds_core_pkg::IDX_SCALE_HI: next_s.dac_current_scale[9:8] = req.wdata[1:0]; // see [RL13]
        dds_core_pkg::IDX_TUNE_LO: next_s.stored_tuning_word[31:0] = req.wdata;
        dds_core_pkg::IDX_TUNE_HI: next_s.stored_tuning_word[47:32] = req.wdata[15:0];
        dds_core_pkg::IDX_PHASE_OFS: next_s.phase_ofs = req.wdata[13:0];
        dds_core_pkg::IDX_COARSE_GAIN: begin
          next_s.coarse_gain_exponent = req.wdata[8:6]; // see [RL15]
          next_s.coarse_gain_multiplier = req.wdata[5:0];
        end
        default: next_s.pll_ctl = s.pll_ctl;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.mode <= dds_core_pkg::MODE_TONE;
      s.pd <= dds_core_pkg::PD_IDLE;
      s.pll_ctl <= dds_core_pkg::RST_PLL_CTL;
      s.fine_detector_divider <= dds_core_pkg::RST_FINE_DIV;
      s.fine_detector_gain <= dds_core_pkg::RST_FINE_GAIN;
      s.dac_current_scale <= dds_core_pkg::RST_SCALE;
      {s.coarse_gain_exponent, s.coarse_gain_multiplier} <= dds_core_pkg::RST_COARSE_GAIN;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign sine_phase = s.sine_phase;
  assign dac_current_scale = s.dac_current_scale;
  assign phase_err = s.phase_err;
  assign fine_tick = s.fine_tick;

  // accumulator advances by the applied step
  a_acc_step: assert property (@(posedge mclk) disable iff (rst)
    ##1 s.acc == 48'($past(s.acc) + $past(s.tuning_step_word)))
    else $error("accumulator did not add step"); // see [RL1]
  // wrap keeps remainder
  a_acc_wrap: assert property (@(posedge mclk) disable iff (rst)
    ({1'b0, s.acc} + {1'b0, s.tuning_step_word}) > 49'h0FFFFFFFFFFFF |=> s.acc < $past(s.acc))
    else $error("accumulator wrap lost"); // see [RL2]
  // single tone lsb cleared
  a_tone_lsb: assert property (@(posedge mclk) disable iff (rst)
    s.mode == dds_core_pkg::MODE_TONE |=> !s.tuning_step_word[0])
    else $error("tone lsb not ignored"); // see [RL7]
  // closed loop follows loop filter
  a_closed_word: assert property (@(posedge mclk) disable iff (rst)
    s.mode == dds_core_pkg::MODE_CLOSED |=> s.tuning_step_word == $past(loop_tuning_word))
    else $error("closed loop word wrong"); // see [RL11]
  // closed loop has no phase offset
  a_closed_ofs: assert property (@(posedge mclk) disable iff (rst)
    s.mode == dds_core_pkg::MODE_CLOSED |=> s.sine_phase == $past(s.acc[47:34]))
    else $error("offset applied in closed loop"); // see [RL12]
  // holdover only after lock
  a_hold_valid: assert property (@(posedge mclk) disable iff (rst)
    s.mode == dds_core_pkg::MODE_HOLD |-> s.locked_once)
    else $error("holdover without prior lock"); // see [RL9]
  // control bit closes loop within one cycle
  a_close_bit: assert property (@(posedge mclk) disable iff (rst)
    s.pll_ctl[0] && !s.pll_ctl[1] && !s.pll_ctl[2] |=> s.mode == dds_core_pkg::MODE_CLOSED)
    else $error("loop did not close"); // see [RL4]
  // helper: cycles since the last fine tick, armed while the divider stays at 5
  logic [6:0] gap_cnt;
  logic gap_div_ok;
  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_cnt <= 7'h00;
      gap_div_ok <= 1'b0;
    end else if (s.fine_tick) begin
      gap_cnt <= 7'h01;
      gap_div_ok <= (s.fine_detector_divider == 4'h5);
    end else begin
      gap_cnt <= (gap_cnt == 7'h7F) ? gap_cnt : gap_cnt + 7'h01;
      if (s.fine_detector_divider != 4'h5) begin
        gap_div_ok <= 1'b0;
      end
    end
  end
  // fine tick spacing equals four times divider, 20 cycles at divider 5
  a_tick_gap: assert property (@(posedge mclk) disable iff (rst)
    s.fine_tick && gap_div_ok && s.fine_detector_divider == 4'h5 |-> gap_cnt == 7'h14)
    else $error("fine tick spacing wrong"); // see [RL16]
  // coarse substitution on overflow
  a_coarse_sub: assert property (@(posedge mclk) disable iff (rst)
    next_s.fine_tick && (fine_over || fine_under) |=> s.phase_err == $past(coarse_scaled))
    else $error("coarse not substituted"); // see [RL19]
endmodule
`default_nettype wire

// file: test/loop_partner.sv
// partner model: divided reference and feedback edges, loop filter word
// assumes bench requests change just after a rising mclk edge
`timescale 1ns/1ps
`default_nettype none
module loop_partner (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench requests
  input wire logic fire,
  input wire logic ref_first,
  input wire logic [7:0] gap,
  input wire logic [47:0] loop_req,
  // to the core
  output logic ref_edge,
  output logic fb_edge,
  output logic [47:0] loop_tuning_word
);
  logic [7:0] cnt;
  // leading edge on fire, lagging edge gap cycles later
  always_ff @(posedge mclk) begin
    loop_tuning_word <= loop_req;
    ref_edge <= 1'b0;
    fb_edge <= 1'b0;
    if (rst) begin
      cnt <= 8'h00;
    end else if (fire) begin
      cnt <= gap;
      ref_edge <= ref_first;
      fb_edge <= !ref_first;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      ref_edge <= (cnt == 8'h01) && !ref_first;
      fb_edge <= (cnt == 8'h01) && ref_first;
    end
  end
endmodule
`default_nettype wire

// file: test/tb_dds_core_phase_detector.sv
// self-checking bench for the synthesizer core over apb
// assumes one apb wait state and the partner model for detector edges
`timescale 1ns/1ps
`default_nettype none
module tb_dds_core_phase_detector;
  logic mclk = 1'b0;
  logic rst, psel, penable, pwrite, ref_lost, fine_over, fine_under, fire, ref_first;
  logic pready, pslverr, err, fine_tick, ref_edge, fb_edge;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, phase_err;
  logic [47:0] est_tuning_word, loop_req, loop_tuning_word;
  logic [13:0] est_phase_word, sine_phase;
  logic [7:0] gap;
  logic [9:0] dac_current_scale;
  logic signed [15:0] fine_meas;
  int bad_count = 0;
  int checked = 0;
  int n;
  // 25 MHz clock
  initial forever #20 mclk = ~mclk;
  // core and far side
  dds_core_phase_detector uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .est_tuning_word, .est_phase_word, .loop_tuning_word, .ref_lost, .ref_edge,
    .fb_edge, .fine_meas, .fine_over, .fine_under, .sine_phase, .dac_current_scale, .phase_err,
    .fine_tick);
  loop_partner far (.mclk, .rst, .fire, .ref_first, .gap, .loop_req, .ref_edge, .fb_edge,
    .loop_tuning_word);
  // verdict and end of run
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // value comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      test_done();
    end
  endtask
  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rdc(input string what, input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask
  // cycles up to the next fine tick
  task automatic tick(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (fine_tick !== 1'b1 && c < 200);
    if (c >= 200) begin
      chk("fine tick", 32'h1, 32'h0);
      test_done();
    end
  endtask
  // phase advance of the sine address per cycle
  task automatic rate(input logic [13:0] d);
    logic [13:0] a;
    repeat (4) @(posedge mclk);
    #1 a = sine_phase;
    @(posedge mclk);
    #1 chk("sine step", {18'h0, d}, {18'h0, sine_phase - a});
  endtask
  // edge pair nine cycles apart, then phase error after two ticks
  task automatic pair(input logic lead, input logic [31:0] exp);
    @(posedge mclk);
    fire <= 1'b1;
    ref_first <= lead;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (12) @(posedge mclk);
    tick(n);
    tick(n);
    chk("phase error", exp, phase_err);
  endtask
  // main sequence
  initial begin
    {rst, psel, penable, pwrite, ref_lost, fine_over, fine_under, fire, ref_first} = 9'h100;
    paddr = 16'h0000;
    pwdata = 32'h0;
    est_tuning_word = 48'h0;
    est_phase_word = 14'h0;
    loop_req = 48'h0;
    gap = 8'h09;
    fine_meas = 16'sh0007;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rdc("fine divider", dds_core_pkg::IDX_FINE_DIV, 32'h5);
    rdc("fine gain", dds_core_pkg::IDX_FINE_GAIN, 32'hC8);
    rdc("pll control", dds_core_pkg::IDX_PLL_CTL, 32'h0);
    apb(1'b0, 14'h0200, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr(dds_core_pkg::IDX_SCALE_LO, 32'hA5);
    wr(dds_core_pkg::IDX_SCALE_HI, 32'h3);
    rdc("scale hi", dds_core_pkg::IDX_SCALE_HI, 32'h3);
    chk("scale out", 32'h3A5, {22'h0, dac_current_scale});
    wr(dds_core_pkg::IDX_PHASE_OFS, 32'h1234);
    rate(14'h0000);
    chk("offset", 32'h1234, {18'h0, sine_phase});
    wr(dds_core_pkg::IDX_PLL_CTL, 32'h1);
    rate(14'h0000);
    chk("closed offset", 32'h0, {18'h0, sine_phase});
    loop_req <= 48'h0004_0000_0000;
    rate(14'h0001);
    wr(dds_core_pkg::IDX_PLL_CTL, 32'h2);
    loop_req <= 48'h0008_0000_0000;
    rate(14'h0001);
    wr(dds_core_pkg::IDX_PLL_CTL, 32'h4);
    rate(14'h0000);
    ref_lost <= 1'b1;
    rate(14'h0001);
    ref_lost <= 1'b0;
    wr(dds_core_pkg::IDX_TUNE_LO, 32'h1);
    wr(dds_core_pkg::IDX_TUNE_HI, 32'h8004);
    wr(dds_core_pkg::IDX_PLL_CTL, 32'h0);
    rate(14'h2001);
    est_tuning_word <= 48'h0008_0000_0000;
    wr(dds_core_pkg::IDX_PLL_CTL, 32'h8);
    rate(14'h0002);
    tick(n);
    tick(n);
    chk("tick period", 32'd20, n);
    wr(dds_core_pkg::IDX_FINE_DIV, 32'h3);
    tick(n);
    tick(n);
    chk("tick period", 32'd12, n);
    tick(n);
    chk("fine result", 32'h578, phase_err);
    wr(dds_core_pkg::IDX_COARSE_GAIN, 32'h168);
    fine_over <= 1'b1;
    pair(1'b1, 32'h000B_4000);
    fine_over <= 1'b0;
    fine_under <= 1'b1;
    pair(1'b0, 32'hFFF4_C000);
    fine_under <= 1'b0;
    wr(dds_core_pkg::IDX_FINE_GAIN, 32'h10);
    tick(n);
    tick(n);
    chk("fine result", 32'h70, phase_err);
    test_done();
  end
endmodule
`default_nettype wire
